// file: tb/hub_desc_monitor.sv
module hub_desc_monitor
    import hub_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // Requests
    input wire logic        setup_valid,
    input wire setup_type   setup,
    input wire logic        in_token,
    // Transmit stream
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire tx_word_type tx_word,
    // Verdicts and status
    input wire logic        req_stall,
    input wire logic        req_ack,
    input wire logic [7:0]  ctrl_status
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic       clr_wake;  // Wakeup clear request seen this cycle
    logic [2:0] words_q;   // Words popped in the current packet

    // Bit 7 of the request type is a don't-care for the clear
    assign clr_wake = setup_valid && setup.req_type[6:0] == 7'h00
        && setup.request == 8'h01 && setup.value == 16'h0001
        && setup.index == 16'h0000 && setup.length == 16'h0000;

    // Count popped words, restart after each packet end
    always_ff @(posedge clk) begin
        if (reset || (tx_valid && tx_ready && tx_word.last))
            words_q <= 3'h0;
        else if (tx_valid && tx_ready)
            words_q <= words_q + 3'h1;
    end

    a_wake_clear: assert property (clr_wake |=> req_ack
        && !req_stall && ctrl_status == 8'h00) else $error("no clear");
    a_ack_cause: assert property (req_ack |-> $past(clr_wake))
        else $error("ack without request");
    a_stall_hold: assert property (!setup_valid |=> $stable(req_stall))
        else $error("stall moved without setup");
    a_devdesc_stall: assert property (setup_valid
        && setup.request == 8'h06 && setup.value == 16'h0100 |=> req_stall)
        else $error("device descriptor not refused");
    a_cfg_taken: assert property (setup_valid
        && setup.req_type == 8'h80 && setup.request == 8'h06
        && setup.value == 16'h0200
        && setup.index == 16'h0000 |=> !req_stall)
        else $error("config request refused");
    a_status_bits: assert property (ctrl_status[7:2] == 6'h00
        && !ctrl_status[0] && !$rose(ctrl_status[1]))
        else $error("status bits wrong");
    a_word_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_word)) else $error("word dropped");
    a_zlp_form: assert property (tx_valid && tx_word.zlp
        |-> tx_word.last && tx_word.data == 8'h00) else $error("bad zlp");
    a_pkt_bound: assert property (tx_valid && tx_ready
        && words_q == 3'h7 |-> tx_word.last) else $error("packet over 8");

    c_wake: cover property (clr_wake);
    c_stall: cover property ($rose(req_stall));
    c_full_pkt: cover property (tx_valid && tx_ready && words_q == 3'h7);
endmodule

// file: tb/hub_desc_tb.sv
module hub_desc_tb
    import hub_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        reset;
    logic        setup_valid;
    setup_type   setup;
    logic        in_token;
    logic        tx_valid;
    logic        tx_ready;
    tx_word_type tx_word;
    logic        req_stall;
    logic        req_ack;
    logic [7:0]  ctrl_status;
    int          fails = 0;       // Mismatches seen
    int          num_checks = 0;  // Comparisons made
    int          cycles = 0;      // Watchdog count

    localparam logic [7:0] CFG_EXP [25] = '{
        8'h09, 8'h02, 8'h22, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0, 8'hFA,
        8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
        8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF};
    localparam logic [7:0] HUB_EXP [9] = '{
        8'h09, 8'h29, 8'h04, 8'h09, 8'h00, 8'h32, 8'h64, 8'h00, 8'h1E};
    // Requests to refuse: device descriptor, address, configuration,
    // clear with an index, config descriptor with an index
    localparam logic [63:0] BAD_TAB [5] = '{
        64'h8006_0100_0000_0012, 64'h0005_0007_0000_0000,
        64'h8008_0000_0000_0001, 64'h0001_0001_0001_0000,
        64'h8006_0200_0001_0009};
    // Boundary lengths around packet and descriptor sizes
    localparam int CORNER [6] = '{1, 8, 9, 16, 25, 64};

    hub_desc u_hub_desc (
        .clk(clk), .reset(reset), .setup_valid(setup_valid),
        .setup(setup), .in_token(in_token), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_word(tx_word), .req_stall(req_stall),
        .req_ack(req_ack), .ctrl_status(ctrl_status));

    hub_host_model u_hub_host_model (
        .clk(clk), .in_token(in_token), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_word(tx_word));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // eight-byte setup as a single pulse
    task automatic send_setup(input setup_type s);
        @(posedge clk);
        setup <= s;
        setup_valid <= 1'b1;
        @(posedge clk);
        setup_valid <= 1'b0;
        // Verdicts settle on the edge that takes the setup; the ack
        // pulse stands only until the next edge
        #1;
    endtask

    // Read a descriptor in packets and compare every word
    task automatic get_desc(input bit hub, input int wl);
        int n;
        int got;
        int exp_n;
        tx_word_type w;
        exp_n = hub ? 9 : 25;
        if (wl < exp_n)
            exp_n = wl;
        send_setup({hub ? 8'hA0 : 8'h80, 8'h06,
                    hub ? 16'h2900 : 16'h0200, 16'h0000, 16'(wl)});
        check(16'(req_stall), 16'h0000);
        got = 0;
        while (got < exp_n) begin
            u_hub_host_model.take_packet(n);
            check(16'(n), 16'(exp_n - got < 8 ? exp_n - got : 8));
            if (n == 0)
                break;
            foreach (u_hub_host_model.pkt_q[i]) begin
                w = u_hub_host_model.pkt_q[i];
                check(16'(w), 16'({1'b0, i == n - 1, hub ?
                    HUB_EXP[got + i] : CFG_EXP[got + i]}));
            end
            got += n;
        end
        $display("test get hub=%0d len=%0d done", hub, wl);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Whole run should take under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    bit rnd_hub;  // Random descriptor choice
    int n0;       // Words in the zero-length reply

    initial begin
        reset = 1'b1;
        setup_valid = 1'b0;
        setup = '0;
        void'($urandom(32'h99AF));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        #1;
        check(16'(ctrl_status), 16'h0002);
        check(16'(tx_valid), 16'h0000);
        for (int k = 0; k < 12; k++)
            get_desc(k[0], CORNER[k / 2]);
        repeat (8) begin
            rnd_hub = 1'($urandom_range(0, 1));
            get_desc(rnd_hub, $urandom_range(1, 64));
        end
        // Zero-length request: one token, one empty packet
        send_setup(64'h8006_0200_0000_0000);
        check(16'(req_stall), 16'h0000);
        u_hub_host_model.take_packet(n0);
        check(16'(n0), 16'h0001);
        check(16'(u_hub_host_model.pkt_q[0]), 16'h0300);
        $display("test zero length done");
        foreach (BAD_TAB[k]) begin
            send_setup(BAD_TAB[k]);
            check(16'(req_stall), 16'h0001);
            check(16'(ctrl_status), 16'h0002);
        end
        $display("test refusals done");
        send_setup(64'h0001_0001_0000_0000);
        check(16'({req_ack, req_stall}), 16'h0002);
        check(16'(ctrl_status), 16'h0000);
        // Second reset restores wakeup; then clear with bit 7 set
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        #1;
        check(16'(ctrl_status), 16'h0002);
        send_setup(64'h8001_0001_0000_0000);
        check(16'({req_ack, req_stall}), 16'h0002);
        check(16'(ctrl_status), 16'h0000);
        $display("test wakeup clear done");
        get_desc(1'b1, 9);
        complete_run();
    end
endmodule

bind hub_desc hub_desc_monitor u_mon (
    .clk(clk), .reset(reset), .setup_valid(setup_valid), .setup(setup),
    .in_token(in_token), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .req_stall(req_stall), .req_ack(req_ack),
    .ctrl_status(ctrl_status));

// file: tb/hub_host_model.sv
module hub_host_model
    import hub_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Endpoint0 data stage
    output logic             in_token,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire tx_word_type tx_word
);
    timeunit 1ns;
    timeprecision 1ps;

    tx_word_type pkt_q [$];  // Words of the latest packet

    initial begin
        in_token = 1'b0;
        tx_ready = 1'b0;
    end

    // Sink takes a word where both are high; random stalls between
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            pkt_q.push_back(tx_word);
        tx_ready <= 1'($urandom_range(0, 1));
    end

    // One IN token, then wait for the packet end under a bound
    task automatic take_packet(output int n);
        int guard;
        guard = 0;
        pkt_q.delete();
        @(posedge clk);
        in_token <= 1'b1;
        @(posedge clk);
        in_token <= 1'b0;
        while ((pkt_q.size() == 0 || !pkt_q[$].last) && guard < 200) begin
            @(posedge clk);
            #1;
            guard++;
        end
        n = pkt_q.size();
    endtask
endmodule

// file: verilog/hub_desc.sv
// Small synchronous FIFO with valid/ready on both sides
// Depth must be a power of two: the pointers simply roll over
// Read data is taken straight from the array, so a word stands
// unchanged until it is popped
module hub_tx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    // Pointer width; the count carries one bit more so full and empty
    // stay apart without a spare slot
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];    // Storage array
    logic [AW-1:0]    wr_ptr_q;         // Next slot to write
    logic [AW-1:0]    rd_ptr_q;         // Next slot to read
    logic [AW:0]      count_q;          // Words held
    logic             push;
    logic             pop;

    // Full and empty are taken straight from the count
    // Handshakes are combinational; the data word comes from the array
    assign in_ready  = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write, no reset needed for data
    // Leaving the array out of reset saves area; stale words are never read
    always_ff @(posedge clk) begin
        if (push) begin
            // Slot is free: the full flag gates every write
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers wrap naturally, depth is a power of two
    always_ff @(posedge clk) begin
        if (reset) begin
            // Both pointers meet at slot zero, buffer empty
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                // Advance past the slot just written
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                // Advance past the word just taken
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // Occupancy tracks simultaneous push and pop
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= '0;
        end else if (push && !pop) begin
            // Fill only
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            // Drain only; push and pop together leave the count alone
            count_q <= count_q - 1'b1;
        end
    end
endmodule

// Descriptor store and endpoint0 request front end of the hub controller
// Only the configuration set, the hub descriptor and the remote wakeup
// clear are served; every other setup is refused with a STALL level.
// The status stage handshake is left to the serial engine.
module hub_desc
    import hub_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Setup stage from the serial engine
    input  wire logic        setup_valid,
    input  wire setup_type   setup,
    // Data stage IN token on endpoint0
    input  wire logic        in_token,
    // Transmit byte stream to the serial engine
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output tx_word_type      tx_word,
    // Handshake verdicts
    output logic             req_stall,
    output logic             req_ack,
    // Controller status
    output logic [7:0]       ctrl_status
);

    // Sequencer and byte counters
    xfer_state_type state_q;            // Transfer sequencer
    logic [5:0]     ptr_q;              // Next descriptor byte
    logic [15:0]    remain_q;           // Bytes still to send
    logic           short_q;            // Data shorter than asked for
    logic [3:0]     pkt_cnt_q;          // Bytes in current packet
    logic           stall_q;            // Latched STALL verdict
    logic           ack_q;              // One-cycle ack pulse
    logic [7:0]     status_q;           // Controller status register
    // Buffer fill side
    logic           fifo_in_valid;      // Word offered to the buffer
    logic           fifo_in_ready;      // Buffer has a free slot
    tx_word_type    fifo_in_word;       // Byte or zero-length marker
    // Setup decode results
    logic           dec_cfg;            // Configuration set request
    logic           dec_hub;            // Hub descriptor request
    logic           dec_wake;           // Clear remote wakeup
    logic [15:0]    grant_len;          // Bytes that will be sent
    logic [15:0]    desc_len;           // Length of chosen descriptor
    logic           push_byte;          // Descriptor byte enters buffer
    logic           pkt_end;            // Byte closes a packet
    logic           last_done;          // Byte closes the data stage

    // Fixed descriptor bytes, configuration set then hub descriptor
    // A case table keeps the store as plain gates, no memory macro
    function automatic logic [7:0] rom(input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            6'h00: v = 8'h09;
            6'h01: v = 8'h02;
            // Two-byte fields are kept low byte first
            // total length
            6'h02: v = 8'h22;
            6'h03: v = 8'h00;
            6'h04: v = 8'h01;
            6'h05: v = 8'h01;
            6'h06: v = 8'h00;
            6'h07: v = 8'hA0;
            6'h08: v = 8'hFA;
            6'h09: v = 8'h09;
            6'h0A: v = 8'h04;
            6'h0B: v = 8'h00;
            6'h0C: v = 8'h00;
            6'h0D: v = 8'h01;
            6'h0E: v = 8'h09;
            6'h0F: v = 8'h00;
            6'h10: v = 8'h00;
            6'h11: v = 8'h00;
            6'h12: v = 8'h07;
            6'h13: v = 8'h05;
            6'h14: v = 8'h81;
            6'h15: v = 8'h03;
            6'h16: v = 8'h01;
            6'h17: v = 8'h00;
            6'h18: v = 8'hFF;
            6'h19: v = 8'h09;
            6'h1A: v = 8'h29;
            6'h1B: v = 8'h04;
            6'h1C: v = 8'h09;
            6'h1D: v = 8'h00;
            6'h1E: v = 8'h32;
            6'h1F: v = 8'h64;
            6'h20: v = 8'h00;
            6'h21: v = 8'h1E;
            // Addresses past the hub descriptor read as zero
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Decode of the eight-byte setup packet
    // The results are only acted on in the cycle that setup_valid marks,
    // so the setup word may change freely at other times
    always_comb begin
        dec_cfg  = (setup.req_type == REQ_TYPE_STD_IN)
                && (setup.request == REQ_GET_DESC)
                && (setup.value == {DESC_TYPE_CONFIG, 8'h00})
                && (setup.index == 16'h0000);
        dec_hub  = (setup.req_type == REQ_TYPE_CLS_IN)
                && (setup.request == REQ_GET_DESC)
                && (setup.value == {DESC_TYPE_HUB, 8'h00})
                && (setup.index == 16'h0000);
        // clear wakeup match, direction bit is ignored
        dec_wake = (setup.req_type[6:0] == REQ_TYPE_DEV_OUT)
                && (setup.request == REQ_CLEAR_FEATURE)
                && (setup.value == FEAT_REMOTE_WAKE)
                && (setup.index == 16'h0000)
                && (setup.length == 16'h0000);
        // Lengths of the two descriptors come from the package
        // set is config, interface, endpoint1 only
        desc_len = dec_hub ? HUB_DESC_LEN : CFG_SET_LEN;
        // truncate to what the host asked for
        grant_len = (setup.length < desc_len) ? setup.length : desc_len;
    end

    // In ST_SEND a byte goes out whenever the buffer accepts one
    // Bytes only move while the buffer has room, so none is lost
    assign push_byte = (state_q == ST_SEND) && fifo_in_ready;
    // split at max packet size or final byte
    assign pkt_end = (pkt_cnt_q == EP0_MAX_PKT - 4'h1)
                  || (remain_q == 16'h0001);
    // A short final packet always ends the stage; a full one only when
    // the host asked for no more than the descriptor holds
    assign last_done = (remain_q == 16'h0001)
                    && ((pkt_cnt_q != EP0_MAX_PKT - 4'h1) || !short_q);

    // Transfer sequencer; a new setup always aborts the old transfer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else if (setup_valid) begin
            // A new setup wins over any transfer in flight
            state_q <= (dec_cfg || dec_hub) ? ST_WAIT : ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Tokens are ignored until a descriptor request
                    state_q <= ST_IDLE;
                end
                ST_WAIT: begin
                    // Zero-length tail leaves through the buffer too
                    if (in_token && remain_q != 16'h0000) begin
                        state_q <= ST_SEND;
                    end else if (in_token && fifo_in_ready) begin
                        // Full buffer drops the token; the host retries
                        state_q <= ST_IDLE;
                    end
                end
                ST_SEND: begin
                    // Packet closed: finish or wait for the next token
                    if (push_byte && pkt_end) begin
                        // short last packet, or a full one when no zero-length packet is owed, ends the data stage
                        if (last_done) begin
                            state_q <= ST_IDLE;
                        end else begin
                            // More bytes, or a zero-length packet, owed
                            state_q <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    // Unreachable; recover to idle
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Byte pointer and count of bytes left
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_q    <= 6'h00;
            remain_q <= 16'h0000;
            short_q  <= 1'b0;
        end else if (setup_valid) begin
            // Start of the chosen descriptor; short_q marks a long request
            ptr_q    <= dec_hub ? HUB_DESC_OFS : CFG_SET_OFS;
            remain_q <= grant_len;
            short_q  <= (setup.length > desc_len);
        end else if (push_byte) begin
            // ascending offset order
            // remain_q reaches zero before the pointer leaves the descriptor
            ptr_q    <= ptr_q + 6'h01;
            remain_q <= remain_q - 16'h0001;
        end
    end

    // Bytes placed in the packet being built
    always_ff @(posedge clk) begin
        // A setup restarts packet framing mid-transfer
        if (reset || setup_valid) begin
            pkt_cnt_q <= 4'h0;
        end else if (push_byte) begin
            // Wrap to zero after the byte that closes a packet
            pkt_cnt_q <= pkt_end ? 4'h0 : pkt_cnt_q + 4'h1;
        end
    end

    // Word handed to the transmit buffer
    always_comb begin
        // Default: the next descriptor byte
        fifo_in_valid     = push_byte;
        fifo_in_word.zlp  = 1'b0;
        fifo_in_word.last = pkt_end;
        fifo_in_word.data = rom(ptr_q);
        if (state_q == ST_WAIT && in_token && remain_q == 16'h0000) begin
            // Nothing left to send: zero-length request, or exact multiple of packet size but less than asked
            fifo_in_valid     = 1'b1;
            fifo_in_word.zlp  = 1'b1;
            fifo_in_word.last = 1'b1;
            fifo_in_word.data = 8'h00;
        end
    end

    // STALL verdict held until the next setup
    // Limitation: the status stage does not clear it
    always_ff @(posedge clk) begin
        if (reset) begin
            stall_q <= 1'b0;
        end else if (setup_valid) begin
            stall_q <= !(dec_cfg || dec_hub || dec_wake);
        end
    end

    // Acknowledge pulse for the no-data clear request
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            // High for one cycle after the accepted clear
            ack_q <= setup_valid && dec_wake;
        end
    end

    // Controller status register; wakeup enabled out of reset
    // Only bit 1 lives here; the other bits read as zero
    always_ff @(posedge clk) begin
        if (reset) begin
            status_q <= CTRL_STATUS_RST;
        end else if (setup_valid && dec_wake) begin
            status_q[RWU_BIT] <= 1'b0;
        end
    end

    // Buffer decouples descriptor reads from the serial engine pace
    // Sixteen words hold two full packets ahead of the engine
    hub_tx_fifo #(
        .WIDTH (TX_WORD_BITS),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_word)
    );

    // Verdicts and status come straight from flip-flops
    assign req_stall   = stall_q;
    assign req_ack     = ack_q;
    assign ctrl_status = status_q;

endmodule

// file: verilog/hub_pkg.sv
// Contract
// - Config descriptor opens 09H, 02H
// - Total length bytes 22H then 00H
// - One interface, config value 01H, string 00H
// - Attribute byte A0H at offset 7
// - Max power byte FAH at offset 8
// - Interface descriptor type 04H, number/alt 00H
// - One endpoint, class 09H, rest 00H
// - Endpoint descriptor length 07H, type 05H
// - Endpoint address 81H, attributes 03H
// - Endpoint max packet 01H then 00H
// - Endpoint polling interval FFH
// - No endpoint0 descriptor in configuration set
// - Hub descriptor nine bytes, type 29H
// - Hub reports four downstream ports
// - Hub characteristics 09H then 00H
// - Power-on-to-good byte 32H
// - Hub controller current byte 64H
// - Removable mask 00H, power mask 1EH
// - Unsupported standard requests answered with STALL
// - Clear Device Feature disables remote wakeup
// - Remote wakeup is controller status bit 1
// - Config request returns set, truncated or short
package hub_pkg;

    // Eight-byte setup packet, byte 0 in the top field
    typedef struct packed {
        logic [7:0]  req_type;
        logic [7:0]  request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } setup_type;

    // One word of the transmit stream
    typedef struct packed {
        logic       zlp;   // Zero-length packet marker, data ignored
        logic       last;  // Last byte of a packet
        logic [7:0] data;
    } tx_word_type;

    typedef enum {
        ST_IDLE,
        ST_WAIT,
        ST_SEND
    } xfer_state_type;

    // Request decode values
    localparam logic [7:0]  REQ_TYPE_STD_IN   = 8'h80;
    localparam logic [7:0]  REQ_TYPE_CLS_IN   = 8'hA0;
    localparam logic [6:0]  REQ_TYPE_DEV_OUT  = 7'h00;
    localparam logic [7:0]  REQ_GET_DESC      = 8'h06;
    localparam logic [7:0]  REQ_CLEAR_FEATURE = 8'h01;
    localparam logic [7:0]  DESC_TYPE_CONFIG  = 8'h02;
    localparam logic [7:0]  DESC_TYPE_HUB     = 8'h29;
    localparam logic [15:0] FEAT_REMOTE_WAKE  = 16'h0001;

    // Descriptor storage layout
    localparam int          ROM_BYTES    = 34;
    localparam logic [5:0]  CFG_SET_OFS  = 6'h00;
    localparam logic [15:0] CFG_SET_LEN  = 16'h0019;
    localparam logic [5:0]  HUB_DESC_OFS = 6'h19;
    localparam logic [15:0] HUB_DESC_LEN = 16'h0009;

    // Endpoint0 packet size
    localparam logic [3:0]  EP0_MAX_PKT  = 4'h8;

    // Controller status register
    localparam int          RWU_BIT         = 1;
    localparam logic [7:0]  CTRL_STATUS_RST = 8'h02;

    // Transmit buffer
    localparam int          TX_FIFO_DEPTH = 16;
    localparam int          TX_WORD_BITS  = $bits(tx_word_type);

endpackage
